// *** include/pwk_pkg.sv ***
`default_nettype none
package pwk_pkg;
    // ****************************************
    // register indices, byte address is index times four
    // ****************************************
    localparam logic [7:0] IDX_STATUS   = 8'h1b;
    localparam logic [7:0] IDX_DIVIDER  = 8'h1c;
    localparam logic [7:0] IDX_WAKE_INT = 8'h1d;
    localparam logic [7:0] IDX_RST_INT  = 8'h1e;
    localparam logic [7:0] IDX_SNAPSHOT = 8'h1f;

    // ****************************************
    // status field positions
    // ****************************************
    localparam int unsigned BIT_WAKE_FLAG  = 7;
    localparam int unsigned BIT_WAKE_CLEAR = 6;
    localparam int unsigned BIT_PAGE       = 5;
    localparam int unsigned BIT_RST_FLAG   = 4;
    localparam int unsigned BIT_RST_CLEAR  = 3;

    // ****************************************
    // reset and forced values
    // ****************************************
    localparam logic [7:0] RST_DIVIDER     = 8'h1f;
    localparam logic [7:0] RST_WAKE_INT    = 8'hff;
    localparam logic [7:0] RST_RST_INT     = 8'hff;
    localparam logic [7:0] DIV_FORCED      = 8'hff;
    localparam logic [7:0] INTERVAL_PARKED = 8'hff;

    // ****************************************
    // wake clock period in oscillator cycles: base plus step times divider
    // ****************************************
    localparam int unsigned DIV_BASE  = 504;
    localparam int unsigned DIV_STEP  = 16;
    localparam int unsigned DIV_CNT_W = 13;

    typedef enum logic [1:0] {
        PWK_BUS_IDLE   = 2'b00,
        PWK_BUS_ACCESS = 2'b01,
        PWK_BUS_ANSWER = 2'b11
    } pwk_bus_state_t;

    function automatic logic [7:0] pwk_byte_addr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction
endpackage
`default_nettype wire

// *** rtl/pwk_lfo_divider.sv ***
`timescale 1ns/10ps
`default_nettype none
module pwk_lfo_divider import pwk_pkg::*; (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       low_freq_osc_i,
    input  wire logic [7:0] wake_clock_divider_i,
    input  wire logic       restart_i,
    output logic            wake_tick_o
);
    typedef struct packed {
        logic                 sync1;
        logic                 sync2;
        logic                 prev;
        logic [DIV_CNT_W-1:0] cnt;
        logic                 tick;
    } pwk_div_state_t;

    pwk_div_state_t       q;
    pwk_div_state_t       d;
    logic [DIV_CNT_W-1:0] period_last;

    // ****************************************
    // oscillator sync and wake clock divider
    // ****************************************
    always_comb begin
        period_last = DIV_CNT_W'(DIV_BASE) + DIV_CNT_W'(DIV_STEP) * DIV_CNT_W'(wake_clock_divider_i)
                      - DIV_CNT_W'(1);
        d       = q;
        d.sync1 = low_freq_osc_i;
        d.sync2 = q.sync1;
        d.prev  = q.sync2;
        d.tick  = 1'b0;
        if (restart_i) begin
            d.cnt = '0;
        end else if (q.sync2 && !q.prev) begin
            if (q.cnt >= period_last) begin
                d.cnt  = '0;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + DIV_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign wake_tick_o = q.tick;
endmodule
`default_nettype wire

// *** rtl/pwk_event_counter.sv ***
`timescale 1ns/10ps
`default_nettype none
module pwk_event_counter #(
    parameter int unsigned W = 8
) (
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] limit_i,
    input  wire logic         restart_i,
    output logic [W-1:0]      count_o,
    output logic              done_o
);
    if (W < 2 || W > 16) begin : g_bad_width
        $error("event counter width out of range");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } pwk_cnt_state_t;

    pwk_cnt_state_t q;
    pwk_cnt_state_t d;

    // ****************************************
    // count ticks up to limit, reload and pulse
    // ****************************************
    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (restart_i) begin
            d.cnt = '0;
        end else if (tick_i && limit_i != '0) begin
            if (q.cnt + W'(1) >= limit_i) begin
                d.cnt  = '0;
                d.done = 1'b1;
            end else begin
                d.cnt = q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count_o = q.cnt;
    assign done_o  = q.done;
endmodule
`default_nettype wire

// *** rtl/pwk_wakeup_counters.sv ***
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pwk_wakeup_counters import pwk_pkg::*; #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              core_clk_i,
    input  wire logic              reset_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              low_freq_osc_i,
    output logic                   wake_event_o,
    output logic                   periodic_reset_o,
    output logic                   wake_interrupt_flag_o,
    output logic                   periodic_reset_flag_o
);
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
        $error("address width out of range");
    end

    if (RST_WAKE_INT == 8'h00 || RST_RST_INT == 8'h00) begin : g_bad_presets
        $error("interval presets must be nonzero");
    end

    if (INTERVAL_PARKED == 8'h00) begin : g_bad_parked
        $error("parked interval limit must be nonzero");
    end

    if (BIT_WAKE_FLAG > 7 || BIT_PAGE > 7 || BIT_RST_FLAG > 7) begin : g_bad_flag_bits
        $error("status flag outside the byte");
    end

    if (BIT_WAKE_CLEAR > 7 || BIT_RST_CLEAR > 7) begin : g_bad_clear_bits
        $error("status clear bit outside the byte");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        pwk_bus_state_t bus;
        logic           pready;
        logic           pslverr;
        logic [31:0]    prdata;
        logic [7:0]     divider;
        logic [7:0]     wake_interval;
        logic [7:0]     reset_interval;
        logic           page;
        logic           wake_flag;
        logic           reset_flag;
        logic           wake_restart;
        logic           reset_restart;
        logic           wake_event;
        logic           reset_event;
    } pwk_top_state_t;

    localparam pwk_top_state_t STATE_RESET = '{
        bus:            PWK_BUS_IDLE,
        pready:         1'b0,
        pslverr:        1'b0,
        prdata:         32'h0000_0000,
        divider:        RST_DIVIDER,
        wake_interval:  RST_WAKE_INT,
        reset_interval: RST_RST_INT,
        page:           1'b0,
        wake_flag:      1'b0,
        reset_flag:     1'b0,
        wake_restart:   1'b0,
        reset_restart:  1'b0,
        wake_event:     1'b0,
        reset_event:    1'b0
    };

    pwk_top_state_t q;
    pwk_top_state_t d;

    logic       wake_tick;
    logic [7:0] interval_limit;
    logic [7:0] interval_count;
    logic       interval_done;
    logic [7:0] reset_count;
    logic       reset_done;
    logic [7:0] wdata;
    logic       wr_commit;
    logic       rd_valid;
    logic [7:0] rd_byte;
    logic       wake_take;
    logic       reset_take;
    logic       wake_fire;
    logic       reset_fire;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        return addr == ADDR_W'(pwk_byte_addr(idx));
    endfunction

    // store only a changed value, and never zero while the other field is zero
    function automatic logic accept(input logic [7:0] nv, input logic [7:0] ov, input logic [7:0] other);
        return (nv != ov) && ((nv != 8'h00) || (other != 8'h00));
    endfunction

    function automatic logic [7:0] status_byte(input logic wflag, input logic page, input logic rflag);
        logic [7:0] b;
        b                = 8'h00;
        b[BIT_WAKE_FLAG] = wflag;
        b[BIT_PAGE]      = page;
        b[BIT_RST_FLAG]  = rflag;
        return b;
    endfunction

    // ****************************************
    // wake clock and counters
    // ****************************************
    pwk_lfo_divider u_divider (
        .core_clk_i           (core_clk_i),
        .reset_i              (reset_i),
        .low_freq_osc_i       (low_freq_osc_i),
        .wake_clock_divider_i (q.divider),
        .restart_i            (q.wake_restart),
        .wake_tick_o          (wake_tick)
    );

    // zero interval keeps the count running parked so reset timing continues
    assign interval_limit = (q.wake_interval == 8'h00) ? INTERVAL_PARKED : q.wake_interval;

    pwk_event_counter #(
        .W (8)
    ) u_interval (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .tick_i     (wake_tick),
        .limit_i    (interval_limit),
        .restart_i  (q.wake_restart),
        .count_o    (interval_count),
        .done_o     (interval_done)
    );

    pwk_event_counter #(
        .W (8)
    ) u_reset (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .tick_i     (interval_done),
        .limit_i    (q.reset_interval),
        .restart_i  (q.reset_restart),
        .count_o    (reset_count),
        .done_o     (reset_done)
    );

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rd_valid = 1'b1;
        rd_byte  = 8'h00;
        if (hit(paddr_i, IDX_STATUS)) begin
            rd_byte = status_byte(q.wake_flag, q.page, q.reset_flag);
        end else if (hit(paddr_i, IDX_DIVIDER)) begin
            rd_byte = q.divider;
        end else if (hit(paddr_i, IDX_WAKE_INT)) begin
            rd_byte = q.wake_interval;
        end else if (hit(paddr_i, IDX_RST_INT)) begin
            rd_byte = q.reset_interval;
        end else if (hit(paddr_i, IDX_SNAPSHOT)) begin
            rd_byte = q.page ? reset_count : interval_count;
        end else begin
            rd_valid = 1'b0;
        end
    end

    assign wdata     = pwdata_i[7:0];
    assign wr_commit = (q.bus == PWK_BUS_ANSWER) && psel_i && penable_i && pwrite_i
                       && pstrb_i[0] && !q.pslverr;

    // ****************************************
    // write acceptance and event strobes
    // ****************************************
    assign wake_take  = accept(wdata, q.wake_interval, q.reset_interval);
    assign reset_take = accept(wdata, q.reset_interval, q.wake_interval);
    assign wake_fire  = interval_done && (q.wake_interval != 8'h00);
    assign reset_fire = reset_done;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d               = q;
        d.wake_restart  = 1'b0;
        d.reset_restart = 1'b0;
        d.wake_event    = wake_fire;
        d.reset_event   = reset_fire;

        case (q.bus)
            PWK_BUS_IDLE: begin
                if (psel_i) begin
                    d.bus = PWK_BUS_ACCESS;
                end
            end
            PWK_BUS_ACCESS: begin
                if (psel_i && penable_i) begin
                    d.bus     = PWK_BUS_ANSWER;
                    d.pready  = 1'b1;
                    d.pslverr = !rd_valid;
                    d.prdata  = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                end else if (!psel_i) begin
                    d.bus = PWK_BUS_IDLE;
                end
            end
            PWK_BUS_ANSWER: begin
                d.bus     = PWK_BUS_IDLE;
                d.pready  = 1'b0;
                d.pslverr = 1'b0;
            end
            default: begin
                d.bus = PWK_BUS_IDLE;
            end
        endcase

        if (wr_commit) begin
            if (hit(paddr_i, IDX_STATUS)) begin
                d.page = wdata[BIT_PAGE];
                if (wdata[BIT_WAKE_CLEAR]) begin
                    d.wake_flag = 1'b0;
                end
                if (wdata[BIT_RST_CLEAR]) begin
                    d.reset_flag = 1'b0;
                end
            end else if (hit(paddr_i, IDX_DIVIDER)) begin
                d.divider = wdata;
            end else if (hit(paddr_i, IDX_WAKE_INT)) begin
                if (wake_take) begin
                    d.wake_interval = wdata;
                    d.wake_restart  = 1'b1;
                    if (wdata == 8'h00) begin
                        d.divider = DIV_FORCED;
                    end
                end
            end else if (hit(paddr_i, IDX_RST_INT)) begin
                if (reset_take) begin
                    d.reset_interval = wdata;
                    d.reset_restart  = 1'b1;
                end
            end
        end

        // a new event wins over a clear in the same cycle
        if (d.wake_event) begin
            d.wake_flag = 1'b1;
        end
        if (d.reset_event) begin
            d.reset_flag = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata_o              = q.prdata;
    assign pready_o              = q.pready;
    assign pslverr_o             = q.pslverr;
    assign wake_event_o          = q.wake_event;
    assign periodic_reset_o      = q.reset_event;
    assign wake_interrupt_flag_o = q.wake_flag;
    assign periodic_reset_flag_o = q.reset_flag;
endmodule
`default_nettype wire

// *** sim/pwk_wakeup_counters_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module pwk_wakeup_counters_assertions #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic              core_clk_i,
    input wire logic              reset_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [3:0]        pstrb_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic              low_freq_osc_i,
    input wire logic              wake_event_o,
    input wire logic              periodic_reset_o,
    input wire logic              wake_interrupt_flag_o,
    input wire logic              periodic_reset_flag_o
);
    // ****************************************
    // bus and event checks
    // ****************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_one_wait;
        !pready_o ##1 pready_o;
    endsequence
    sequence s_clear_write;
        psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == 8'h6c && pwdata_i[6];
    endsequence
    sequence s_rst_clear_write;
        psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == 8'h6c && pwdata_i[3];
    endsequence

    a_ready_one_wait: assert property (s_setup |=> s_one_wait) else $error("pready not on third cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
    a_rdata_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper read bits set");
    a_wake_pulse: assert property (wake_event_o |=> !wake_event_o) else $error("wake pulse too long");
    a_wake_flag_set: assert property (wake_event_o |-> wake_interrupt_flag_o) else $error("wake flag not set");
    a_reset_after_wake: assert property (periodic_reset_o |-> $past(wake_event_o)) else $error("reset not after wake");
    a_reset_flag_set: assert property (periodic_reset_o |-> periodic_reset_flag_o) else $error("reset flag unset");
    a_wake_flag_clear: assert property ($fell(wake_interrupt_flag_o) |->
        $past(psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == 8'h6c && pwdata_i[6]))
        else $error("wake flag fell without clear");
    a_wake_clear_works: assert property (s_clear_write |=> !wake_interrupt_flag_o || wake_event_o)
        else $error("wake flag clear had no effect");
    a_reset_clear_works: assert property (s_rst_clear_write |=> !periodic_reset_flag_o || periodic_reset_o)
        else $error("reset flag clear had no effect");
endmodule
bind pwk_wakeup_counters pwk_wakeup_counters_assertions #(.ADDR_W(ADDR_W)) chk_inst (
    .core_clk_i, .reset_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
    .pslverr_o, .low_freq_osc_i, .wake_event_o, .periodic_reset_o, .wake_interrupt_flag_o, .periodic_reset_flag_o
);
`default_nettype wire

// *** sim/pwk_wakeup_counters_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module pwk_wakeup_counters_tb_top import pwk_pkg::*;;
    logic        clk, rst, psel, pen, pwr, osc = 1'b0, pready, perr, wev, reset_interval_count, wflag, rflag, er;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, rd;
    int          num_errors = 0, samples_checked = 0, cyc = 0, t_last = 0, osc_cnt = 0, dt;

    pwk_wakeup_counters #(.ADDR_W(8)) pwk_wakeup_counters_inst (
        .core_clk_i(clk), .reset_i(rst), .paddr_i(paddr), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
        .low_freq_osc_i(osc), .wake_event_o(wev), .periodic_reset_o(reset_interval_count), .wake_interrupt_flag_o(wflag),
        .periodic_reset_flag_o(rflag)
    );

    // ****************************************
    // clock, oscillator of six core cycles, cycle count
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc     <= cyc + 1;
        osc_cnt <= (osc_cnt == 5) ? 0 : osc_cnt + 1;
        osc     <= (osc_cnt < 3);
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= wr;
        paddr  <= {idx[5:0], 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        check(n < 20, 1'b1);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
        check(er, 1'b0);
    endtask
    task automatic wait_wake(input logic exp_rst, output int d);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wev !== 1'b1 && n < 4000);
        check(n < 4000, 1'b1);
        d = cyc - t_last;
        t_last = cyc;
        @(posedge clk);
        check(reset_interval_count, exp_rst);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_vals;
        rd_chk(IDX_WAKE_INT, 32'hff);
        rd_chk(IDX_RST_INT, 32'hff);
        apb(1'b0, 8'h00, 8'h00);
        check(er, 1'b1);
    endtask
    task automatic t_interlock;
        apb(1'b1, IDX_WAKE_INT, 8'h00);
        rd_chk(IDX_WAKE_INT, 32'h0);
        rd_chk(IDX_DIVIDER, 32'hff);
        apb(1'b1, IDX_RST_INT, 8'h00);
        rd_chk(IDX_RST_INT, 32'hff);
        apb(1'b1, IDX_DIVIDER, 8'h00);
        apb(1'b1, IDX_WAKE_INT, 8'h01);
        apb(1'b1, IDX_RST_INT, 8'h00);
        rd_chk(IDX_RST_INT, 32'h0);
        apb(1'b1, IDX_WAKE_INT, 8'h00);
        rd_chk(IDX_WAKE_INT, 32'h1);
    endtask
    task automatic t_events;
        apb(1'b1, IDX_WAKE_INT, 8'h03);
        apb(1'b1, IDX_WAKE_INT, 8'h01);
        t_last = cyc;
        apb(1'b1, IDX_RST_INT, 8'h02);
        wait_wake(1'b0, dt);
        check(dt >= 3018 && dt <= 3040, 1'b1);
        rd_chk(IDX_SNAPSHOT, 32'h0);
        wait_wake(1'b1, dt);
        check(dt, 3024);
        check({wflag, rflag}, 2'b11);
        rd_chk(IDX_STATUS, 32'h90);
        apb(1'b1, IDX_STATUS, 8'h48);
        rd_chk(IDX_STATUS, 32'h0);
    endtask
    task automatic t_same_value;
        repeat (1000) @(posedge clk);
        apb(1'b1, IDX_WAKE_INT, 8'h01);
        wait_wake(1'b0, dt);
        check(dt, 3024);
        apb(1'b1, IDX_STATUS, 8'h20);
        rd_chk(IDX_SNAPSHOT, 32'h1);
        apb(1'b1, IDX_RST_INT, 8'h02);
        wait_wake(1'b1, dt);
        check(dt, 3024);
        rd_chk(IDX_STATUS, 32'hb0);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        rst    = 1'b1;
        psel   = 1'b0;
        pen    = 1'b0;
        pwr    = 1'b0;
        paddr  = 8'h00;
        pwdata = 32'h0;
        pstrb  = 4'h1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset_vals();
        t_interlock();
        t_events();
        t_same_value();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
